/* File: rtl/adc_pkg.sv */
// constants, types and helpers shared by the converter control design
`default_nettype none
package adc_pkg;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int RES_BITS    = 10;   // result resolution
  localparam int NUM_CHAN    = 12;   // analog channels
  localparam int CHAN_W      = 4;    // channel field width
  localparam int ADR_W       = 5;    // byte address width
  localparam int DAT_W       = 8;    // bus data width
  localparam int CONV_STATES = 266;  // conversion states; the engine is busy RES_BITS x STEP_CYCLES = 260 clocks
  localparam int STEP_CYCLES = CONV_STATES / RES_BITS; // clocks per bit trial

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADR_RESULT_LAST = 5'h17; // last result byte
  localparam logic [4:0] ADR_CTRL_STATUS = 5'h18; // control/status
  localparam logic [4:0] ADR_CONTROL     = 5'h19; // control

  // control/status fields
  localparam int CS_END_FLAG = 7;
  localparam int CS_IRQ_EN   = 6;
  localparam int CS_MODE_HI  = 5;
  localparam int CS_MODE_LO  = 4;
  localparam int CS_CHAN_LSB = 0;
  // control fields
  localparam int CR_GO = 5;
  localparam logic [7:0] CR_RESERVED = 8'h1F; // reserved bits read 1
  localparam logic [1:0] MODE_SINGLE = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_CONVERT, ST_FINISH} seq_state_e;

  typedef struct packed {
    logic [CHAN_W-1:0]   chan;   // converted channel
    logic [RES_BITS-1:0] value;  // converted value
  } conv_result_s;

  // first channel of the scan group holding ch
  function automatic logic [CHAN_W-1:0] scan_first(input logic [CHAN_W-1:0] ch);
    return {ch[3:2], 2'h0};
  endfunction : scan_first

  // upper result byte, value left aligned
  function automatic logic [7:0] hi_byte(input logic [RES_BITS-1:0] v);
    return v[9:2];
  endfunction : hi_byte

  // lower result byte, two bits at the top
  function automatic logic [7:0] lo_byte(input logic [RES_BITS-1:0] v);
    return {v[1:0], 6'h00};
  endfunction : lo_byte

endpackage : adc_pkg
`default_nettype wire

/* File: rtl/sar_engine.sv */
// successive approximation bit-trial engine
`timescale 1ns/1ps
`default_nettype none
module sar_engine #(
  parameter int WIDTH = adc_pkg::RES_BITS,
  parameter int STEPS = adc_pkg::STEP_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,   // begin a conversion
  input  wire logic             abort_i,   // stop at once
  input  wire logic             comp_i,    // 1: input at or above trial
  output logic [WIDTH-1:0]      trial_o,   // dac trial code
  output logic                  busy_o,
  output logic                  done_o     // one-cycle end pulse
);
  localparam int BIT_W  = $clog2(WIDTH);
  localparam int STEP_W = $clog2(STEPS + 1);

  logic [WIDTH-1:0]  trial_reg;  // trial / result
  logic [BIT_W-1:0]  bit_reg;    // bit under trial
  logic [STEP_W-1:0] step_reg;   // settle count
  logic              busy_reg;
  logic              done_reg;
  logic              step_end;

  assign step_end = busy_reg && (step_reg == STEP_W'(STEPS - 1));

  // ---------------------------------------------------------------
  // bit trials, msb first
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      busy_reg  <= 1'b0;
      trial_reg <= '0;
      bit_reg   <= '0;
      step_reg  <= '0;
    end else if (start_i) begin
      busy_reg  <= 1'b1;
      bit_reg   <= BIT_W'(WIDTH - 1);
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      step_reg  <= '0;
    end else if (step_end) begin
      step_reg           <= '0;
      trial_reg[bit_reg] <= comp_i;
      if (bit_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        bit_reg                <= bit_reg - 1'b1;
        trial_reg[bit_reg - 1] <= 1'b1;
      end
    end else if (busy_reg) begin
      step_reg <= step_reg + 1'b1;
    end
  end

  // end pulse after the last trial
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= step_end && (bit_reg == '0) && !start_i;
    end
  end

  assign trial_o = trial_reg;
  assign busy_o  = busy_reg;
  assign done_o  = done_reg;
endmodule : sar_engine
`default_nettype wire

/* File: rtl/byte_hold_latch.sv */
// holding latch for the lower result byte
`timescale 1ns/1ps
`default_nettype none
module byte_hold_latch #(
  parameter int WIDTH = adc_pkg::DAT_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,  // upper-byte read
  input  wire logic [WIDTH-1:0] d_i,     // live lower byte
  output logic [WIDTH-1:0]      q_o
);
  logic [WIDTH-1:0] hold_reg;

  // load only on upper-byte read, hold otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= '0;
    end else if (load_i) begin
      hold_reg <= d_i;
    end
  end

  assign q_o = hold_reg;
endmodule : byte_hold_latch
`default_nettype wire

/* File: rtl/adc_readout_single_mode_ctrl.sv */
// converter control: byte read path, sequencer and wishbone slave
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_single_mode_ctrl (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // ---- classic wishbone slave, 8-bit data ----
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [adc_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [0:0]                  wb_sel_i,
  input  wire logic [adc_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [adc_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  // ---- analog front end ----
  input  wire logic                        comp_i,
  output logic      [adc_pkg::RES_BITS-1:0] trial_o,
  output logic      [adc_pkg::CHAN_W-1:0]  sample_chan_o,
  output logic                             converting_o,
  // ---- interrupt and transfer controller ----
  input  wire logic                        dtc_service_i,
  output logic                             conversion_end_irq_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [adc_pkg::RES_BITS-1:0] result_mem [adc_pkg::NUM_CHAN]; // result registers
  adc_pkg::seq_state_e          state_reg;       // sequencer state
  logic [adc_pkg::CHAN_W-1:0]   cur_chan_reg;    // channel converting
  logic [adc_pkg::CHAN_W-1:0]   chan_reg;        // selected channel
  logic [1:0]                   mode_reg;        // mode_select_hi/lo
  logic                         irq_en_reg;      // end_interrupt_enable
  logic                         flag_reg;        // conversion_end_flag
  logic                         armed_reg;       // flag read while 1
  logic                         go_reg;          // conversion_go_bit
  logic                         ack_reg;
  logic [adc_pkg::DAT_W-1:0]    dat_reg;
  logic [adc_pkg::DAT_W-1:0]    dat_next;
  logic [adc_pkg::DAT_W-1:0]    latch_q;         // held lower byte
  logic [adc_pkg::CHAN_W-1:0]   res_idx;         // result register addressed
  logic                         bus_take;        // request taken this edge
  logic                         rd_take;
  logic                         wr_take;
  logic                         is_result;
  logic                         is_hi;
  logic                         latch_load;
  logic                         wr_cs;
  logic                         wr_cr;
  logic                         single_mode;
  logic                         eng_start;
  logic                         eng_abort;
  logic                         eng_busy;
  logic                         eng_done;
  logic                         flag_set;
  logic                         flag_clr;
  logic [adc_pkg::RES_BITS-1:0] eng_value;
  adc_pkg::conv_result_s        finished;        // result with its channel

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign bus_take   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign rd_take    = bus_take && !wb_we_i;
  assign wr_take    = bus_take && wb_we_i && wb_sel_i[0];
  assign is_result  = (wb_adr_i <= adc_pkg::ADR_RESULT_LAST);
  assign is_hi      = !wb_adr_i[0];              // even byte is upper
  assign res_idx    = wb_adr_i[4:1];
  assign latch_load = rd_take && is_result && is_hi;
  assign wr_cs      = wr_take && (wb_adr_i == adc_pkg::ADR_CTRL_STATUS);
  assign wr_cr      = wr_take && (wb_adr_i == adc_pkg::ADR_CONTROL);
  assign single_mode = (mode_reg == adc_pkg::MODE_SINGLE);

  // lower byte copy for the holding latch
  byte_hold_latch #(
    .WIDTH (adc_pkg::DAT_W)
  ) u_latch (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (latch_load),
    .d_i    (adc_pkg::lo_byte(result_mem[res_idx])),
    .q_o    (latch_q)
  );

  // ---------------------------------------------------------------
  // read data mux
  // ---------------------------------------------------------------
  always_comb begin
    dat_next = '0;                                // unmapped reads 0
    if (is_result) begin
      if (is_hi) begin
        dat_next = adc_pkg::hi_byte(result_mem[res_idx]);
      end else begin
        dat_next = latch_q;
      end
    end else if (wb_adr_i == adc_pkg::ADR_CTRL_STATUS) begin
      dat_next[adc_pkg::CS_END_FLAG] = flag_reg;
      dat_next[adc_pkg::CS_IRQ_EN]   = irq_en_reg;
      dat_next[adc_pkg::CS_MODE_HI]  = mode_reg[1];
      dat_next[adc_pkg::CS_MODE_LO]  = mode_reg[0];
      dat_next[adc_pkg::CS_CHAN_LSB +: adc_pkg::CHAN_W] = chan_reg;
    end else if (wb_adr_i == adc_pkg::ADR_CONTROL) begin
      dat_next = adc_pkg::CR_RESERVED;
      dat_next[adc_pkg::CR_GO] = go_reg;
    end
  end

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= bus_take;
      if (rd_take) begin
        dat_reg <= dat_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ---------------------------------------------------------------
  // control/status fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= 1'b0;
      mode_reg   <= adc_pkg::MODE_SINGLE;
      chan_reg   <= '0;
    end else if (wr_cs) begin
      irq_en_reg <= wb_dat_i[adc_pkg::CS_IRQ_EN];
      mode_reg   <= {wb_dat_i[adc_pkg::CS_MODE_HI], wb_dat_i[adc_pkg::CS_MODE_LO]};
      chan_reg   <= wb_dat_i[adc_pkg::CS_CHAN_LSB +: adc_pkg::CHAN_W];
    end
  end

  // end flag: set wins over either clear
  assign flag_set = (state_reg == adc_pkg::ST_FINISH);
  assign flag_clr = (wr_cs && armed_reg && !wb_dat_i[adc_pkg::CS_END_FLAG])
                  || dtc_service_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // read-while-set arms the software clear; a control/status write disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (rd_take && wb_adr_i == adc_pkg::ADR_CTRL_STATUS && flag_reg) begin
      armed_reg <= 1'b1;
    end else if (wr_cs || !flag_reg) begin
      armed_reg <= 1'b0;
    end
  end

  assign conversion_end_irq_o = flag_reg && irq_en_reg;

  // ---------------------------------------------------------------
  // go bit: software write wins over the self-clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_reg <= 1'b0;
    end else if (wr_cr) begin
      go_reg <= wb_dat_i[adc_pkg::CR_GO];
    end else if (flag_set && single_mode) begin
      go_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign eng_start = go_reg && ((state_reg == adc_pkg::ST_IDLE)
                   || (state_reg == adc_pkg::ST_FINISH && !single_mode));
  assign eng_abort = (state_reg == adc_pkg::ST_CONVERT) && !go_reg;

  sar_engine #(
    .WIDTH (adc_pkg::RES_BITS),
    .STEPS (adc_pkg::STEP_CYCLES)
  ) u_sar (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (eng_start),
    .abort_i (eng_abort),
    .comp_i  (comp_i),
    .trial_o (eng_value),
    .busy_o  (eng_busy),
    .done_o  (eng_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= adc_pkg::ST_IDLE;
      cur_chan_reg <= '0;
    end else begin
      unique case (state_reg)
        adc_pkg::ST_IDLE: begin
          if (go_reg) begin
            state_reg    <= adc_pkg::ST_CONVERT;
            cur_chan_reg <= single_mode ? chan_reg : adc_pkg::scan_first(chan_reg);
          end
        end
        adc_pkg::ST_CONVERT: begin
          if (!go_reg) begin
            state_reg <= adc_pkg::ST_IDLE;        // stopped by software
          end else if (eng_done) begin
            state_reg <= adc_pkg::ST_FINISH;
          end
        end
        adc_pkg::ST_FINISH: begin
          if (single_mode || !go_reg) begin
            state_reg <= adc_pkg::ST_IDLE;
          end else begin
            state_reg    <= adc_pkg::ST_CONVERT;
            cur_chan_reg <= (cur_chan_reg == chan_reg) ? adc_pkg::scan_first(chan_reg)
                                                       : cur_chan_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // result stored the cycle before the flag rises
  assign finished = '{chan: cur_chan_reg, value: eng_value};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < adc_pkg::NUM_CHAN; i++) begin
        result_mem[i] <= '0;
      end
    end else if (eng_done && state_reg == adc_pkg::ST_CONVERT && go_reg) begin
      result_mem[finished.chan] <= finished.value;
    end
  end

  assign trial_o       = eng_value;
  assign sample_chan_o = cur_chan_reg;
  assign converting_o  = eng_busy;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus and read path
  a_ack_one_cycle: assert property (bus_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  a_hi_loads_latch: assert property (latch_load |=>
      latch_q == adc_pkg::lo_byte($past(result_mem[res_idx])))
    else $error("upper read did not load latch");
  a_lo_from_latch: assert property (rd_take && is_result && !is_hi |=>
      wb_ack_o && wb_dat_o == latch_q)
    else $error("lower read not from latch");
  // sequencer, flag and interrupt
  a_go_starts: assert property (state_reg == adc_pkg::ST_IDLE && go_reg |=>
      state_reg == adc_pkg::ST_CONVERT ##1 eng_busy || !go_reg)
    else $error("go did not start conversion");
  a_single_clears: assert property (flag_set && single_mode && !wr_cr |=>
      !go_reg && state_reg == adc_pkg::ST_IDLE)
    else $error("single mode go bit not cleared");
  a_flag_sets: assert property (flag_set |=>
      flag_reg ##0 (conversion_end_irq_o == irq_en_reg))
    else $error("end flag or irq wrong");
  a_irq_rises: assert property (flag_set && irq_en_reg && !wr_cs
      |=> conversion_end_irq_o)
    else $error("end interrupt not raised");
  a_no_blind_clear: assert property (flag_reg && wr_cs && !armed_reg && !dtc_service_i
      |=> flag_reg)
    else $error("flag cleared without prior read");
  a_sw_clear: assert property (wr_cs && armed_reg && !wb_dat_i[adc_pkg::CS_END_FLAG]
      && !flag_set |=> !flag_reg)
    else $error("armed write of 0 did not clear flag");
  a_dtc_clears: assert property (dtc_service_i && !flag_set |=> !flag_reg)
    else $error("transfer service did not clear flag");
  a_scan_keeps_go: assert property (flag_set && !single_mode && go_reg && !wr_cr
      |=> go_reg && state_reg == adc_pkg::ST_CONVERT)
    else $error("scan did not restart");
  a_result_first: assert property (eng_done && state_reg == adc_pkg::ST_CONVERT && go_reg
      |=> result_mem[$past(cur_chan_reg)] == $past(eng_value) && flag_set)
    else $error("result not stored before flag");
  // holding latch
  a_latch_holds: assert property (!latch_load |=> $stable(latch_q))
    else $error("latch changed without upper read");

  // main scenarios
  c_single_done: cover property (single_mode && flag_set ##1 !go_reg);
  c_scan_wrap: cover property (flag_set && !single_mode && cur_chan_reg == chan_reg ##1 go_reg);
  c_sw_clear: cover property (armed_reg && wr_cs ##1 !flag_reg);
  c_dtc_clear: cover property (flag_reg && dtc_service_i ##1 !flag_reg);
  c_lo_read: cover property (rd_take && is_result && !is_hi);
endmodule : adc_readout_single_mode_ctrl
`default_nettype wire

/* File: verification/analog_src.sv */
// analog front end model: comparator against a held input level
`timescale 1ns/1ps
`default_nettype none
module analog_src (
  input  wire logic [9:0] level_i,  // analog input, as a code
  input  wire logic [9:0] trial_i,  // dac trial code from the block
  output logic            comp_o    // 1: input at or above trial
);
  // ---------------------------------------------------------------
  // ideal comparator, no offset
  // ---------------------------------------------------------------
  assign comp_o = (level_i >= trial_i);
endmodule : analog_src
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, comp_i, dtc_service_i;
  logic [4:0] wb_adr_i;
  logic [0:0] wb_sel_i;
  logic [7:0] wb_dat_i, wb_dat_o, q, prev_lo;
  logic       wb_ack_o, converting_o, conversion_end_irq_o, en;
  logic [9:0] trial_o, level;
  logic [3:0] sample_chan_o, ch;
  logic [15:0] lfsr;     // random source
  int         failures, compares, i, n;

  adc_readout_single_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_i(comp_i),
    .trial_o(trial_o), .sample_chan_o(sample_chan_o), .converting_o(converting_o),
    .dtc_service_i(dtc_service_i), .conversion_end_irq_o(conversion_end_irq_o));
  analog_src fe (.level_i(level), .trial_i(trial_o), .comp_o(comp_i));

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // expected upper and lower bytes of a left-aligned result
  function automatic logic [7:0] exp_hi(input logic [9:0] v);
    return v[9:2];
  endfunction : exp_hi
  function automatic logic [7:0] exp_lo(input logic [9:0] v);
    return {v[1:0], 6'h00};
  endfunction : exp_lo
  // galois lfsr step
  function automatic logic [15:0] step(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
  endfunction : step

  // closing report
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // compare one value
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one classic wishbone cycle, waits for ack under a bound
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 20) begin
      failures++;
      results();
    end
  endtask : bus

  // read and compare
  task automatic rd(input string what, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(what, {8'h00, e}, {8'h00, q});
  endtask : rd

  // bounded wait for one conversion to run and finish
  task automatic wait_end;
    n = 0;
    while (converting_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    // never started: force the timeout path below
    if (n >= 20) begin
      n = 600;
    end
    while (converting_o !== 1'b0 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 600) begin
      failures++;
      results();
    end
    repeat (2) @(posedge clk_i);
  endtask : wait_end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, dtc_service_i} = 4'h0;
    wb_adr_i = 5'h00;
    wb_sel_i = 1'b1;
    wb_dat_i = 8'h00;
    level = 10'h000;
    failures = 0;
    compares = 0;
    prev_lo = 8'h00;
    lfsr = 16'hC767;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped place
    rd("ctrl_status", 5'h18, 8'h00);
    rd("control", 5'h19, 8'h1F);
    rd("result_hi0", 5'h00, 8'h00);
    rd("unmapped", 5'h1F, 8'h00);
    for (i = 0; i < 5; i++) begin
      lfsr = step(step(lfsr));
      ch = lfsr[15:12] % 12;
      level <= (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : lfsr[9:0];
      en = i[0];
      if (i == 4) begin
        ch = 4'h9;
      end
      bus(1'b1, 5'h18, {1'b0, en, 2'h0, ch});
      bus(1'b1, 5'h19, 8'h20);
      rd("go_busy", 5'h19, 8'h3F);
      chk("chan", {12'h000, ch}, {12'h000, sample_chan_o});
      wait_end();
      chk("irq", {15'h0000, en}, {15'h0000, conversion_end_irq_o});
      chk("trial", {6'h00, level}, {6'h00, trial_o});
      chk("idle", 16'h0000, {15'h0000, converting_o});
      rd("go_clear", 5'h19, 8'h1F);
      rd("lo_stale", {ch, 1'b1}, prev_lo);
      rd("hi", {ch, 1'b0}, exp_hi(level));
      rd("lo", {ch, 1'b1}, exp_lo(level));
      prev_lo = exp_lo(level);
      // write of 0 with no prior read must leave the flag
      bus(1'b1, 5'h18, {1'b0, en, 2'h0, ch});
      if (i >= 2) begin
        @(posedge clk_i);
        dtc_service_i <= 1'b1;
        @(posedge clk_i);
        dtc_service_i <= 1'b0;
      end
      rd("flag_kept", 5'h18, {i < 2, en, 2'h0, ch});
      bus(1'b1, 5'h18, {1'b0, en, 2'h0, ch});
      rd("flag_clr", 5'h18, {1'b0, en, 2'h0, ch});
      chk("irq_clr", 16'h0000, {15'h0000, conversion_end_irq_o});
    end
    // scan mode keeps go set across the restart
    level <= 10'h155;
    bus(1'b1, 5'h18, 8'h11);
    bus(1'b1, 5'h19, 8'h20);
    wait_end();
    repeat (30) @(posedge clk_i);
    rd("scan_go", 5'h19, 8'h3F);
    chk("scan_busy", 16'h0001, {15'h0000, converting_o});
    bus(1'b1, 5'h19, 8'h00);
    rd("scan_stop", 5'h19, 8'h1F);
    rd("scan_hi", 5'h00, exp_hi(level));
    results();
  end
endmodule : tb_top
`default_nettype wire
